// ---- inc/gly_pkg.sv ----
// shared constants and types of the (23,12) golay codec
package gly_pkg;

    // code geometry
    localparam int GLY_N = 23;            // codeword length
    localparam int GLY_K = 12;            // information bits
    localparam int GLY_PAR = 11;          // check bits
    localparam int GLY_BLK = 24;          // half-rate block, codeword plus fill bit
    localparam int GLY_ALIGN = 12;        // rotations that restore alignment after correction
    localparam int GLY_STEPS = 46;        // single-shift steps per codeword
    localparam int GLY_FIFO_DEPTH = 8;    // bits in the output buffer, one per entry

    // generator polynomial without its x^11 term: x^10+x^6+x^5+x^4+x^2+1
    localparam logic [10:0] GLY_GEN_LOW = 11'h475;
    // syndromes of a lone error at x^16 and at x^17
    localparam logic [10:0] GLY_SYN_A = 11'h366;
    localparam logic [10:0] GLY_SYN_B = 11'h6CC;
    // counter preloads; extra error position is base plus preload
    localparam logic [1:0] GLY_PRE_A = 2'h2;
    localparam logic [1:0] GLY_PRE_B = 2'h3;
    localparam logic [4:0] GLY_EXTRA_BASE = 5'hE;
    // weight limits of the three threshold detectors
    localparam logic [3:0] GLY_WT_ALL = 4'h3;
    localparam logic [3:0] GLY_WT_ONE = 4'h2;
    // value sent in the fill position
    localparam logic GLY_FILL_VAL = 1'b0;

    // decoder phases, one-hot
    typedef enum logic [4:0] {
        GLY_D_LOAD = 5'h01,
        GLY_D_TEST = 5'h02,
        GLY_D_CORR = 5'h04,
        GLY_D_ALIGN = 5'h08,
        GLY_D_SHIFT = 5'h10
    } gly_dphase_t;

    // encoder phases, one-hot
    typedef enum logic [2:0] {
        GLY_E_INFO = 3'h1,
        GLY_E_PAR = 3'h2,
        GLY_E_FILL = 3'h4
    } gly_ephase_t;

    // one serial bit with its end-of-word mark
    typedef struct packed {
        logic last;
        logic data;
    } gly_bit_t;

endpackage

// ---- src/gly_fifo.sv ----
// shift-style fifo with registered head, valid and ready
`timescale 1ns/1ns
`default_nettype none

module gly_fifo #(
    parameter int W = 2,
    parameter int DEPTH = 8,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready,
    output logic [LW-1:0] level
);
    import gly_pkg::*;

    // whole state; entry 0 is always the head so the output is a flop
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [LW-1:0] level;
        logic valid;
        logic ready;
    } gly_fifo_st_t;

    gly_fifo_st_t q;
    gly_fifo_st_t next_q;
    logic pop;
    logic push;
    logic [LW-1:0] lv;

    // next state: pop shifts every entry down, push fills behind the tail
    always_comb begin
        next_q = q;
        pop = q.valid && out_ready;
        push = in_valid && q.ready;
        lv = q.level - LW'(pop);
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_q.mem[i] = q.mem[i + 1];
            end
        end
        if (push) begin
            next_q.mem[lv] = in_data;
        end
        next_q.level = lv + LW'(push);
        // flags are registered so both sides see flop outputs
        next_q.valid = (next_q.level != '0);
        next_q.ready = (next_q.level != LW'(DEPTH));
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{mem: '0, level: '0, valid: 1'b0, ready: 1'b1};
        end else begin
            q <= next_q;
        end
    end

    assign in_ready = q.ready;
    assign out_valid = q.valid;
    assign out_data = q.mem[0];
    assign level = q.level;

endmodule

`default_nettype wire

// ---- src/gly_codec.sv ----
// bit-serial (23,12) golay encoder and error-trapping decoder
//
// Overview of operation
// [R1] load shifts codeword in, previous word out
// [R2] fill bit of each block is dropped
// [R3] after load, test detectors in fixed priority
// [R4] first detector: 11 correcting shifts
// [R5] then realign codeword, go to shift step
// [R6] second detector: preload 2, fix extra error
// [R7] third detector: preload 3, same sequence
// [R8] no detector fires: go to shift step
// [R9] shift step: one rotation with feedback
// [R10] after 46 shift steps, load next word
// [R11] always deliver a word; right for three errors
// [R12] check bits from the generator polynomial
// [R13] eleven check bits per twelve info bits
// [R14] systematic order: info bits, then parity
// [R15] one input bit per clock while ready
`timescale 1ns/1ns
`default_nettype none

module gly_codec #(
    parameter int FIFO_DEPTH = gly_pkg::GLY_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    // encoder input: information bits
    input wire logic enc_in_bit,
    input wire logic enc_in_valid,
    output logic enc_in_ready,
    // encoder output: 24-bit blocks toward the link
    output gly_pkg::gly_bit_t enc_out,
    output logic enc_out_valid,
    input wire logic enc_out_ready,
    // decoder input from the receive path
    input wire logic rx_bit,
    input wire logic rx_valid,
    output logic rx_ready,
    // corrected codewords toward the user
    output gly_pkg::gly_bit_t usr_data,
    output logic usr_valid,
    input wire logic usr_ready
);
    import gly_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH + 1);

    // all codec state in one record
    typedef struct packed {
        gly_dphase_t phase;     // decoder phase
        logic [22:0] cw;        // codeword register, x^22 at the top
        logic [10:0] syn;       // syndrome register, x^10 at the top
        logic [4:0] cnt;        // load, correction and realign count
        logic [5:0] steps;      // shift steps done on this word
        logic [1:0] xcnt;       // preload naming the extra error
        logic xfix;             // extra error still to be flipped
        logic have_prev;        // a corrected word is waiting to leave
        logic rx_ready;         // registered input ready
        gly_ephase_t ephase;    // encoder phase
        logic [4:0] ecnt;       // encoder bit count within phase
        logic [10:0] par;       // encoder check register
        gly_bit_t obit;         // encoder output bit
        logic ovalid;           // encoder output valid
        logic in_ready;         // registered encoder input ready
    } gly_st_t;

    gly_st_t q;
    gly_st_t next_q;

    // decoder side of the output buffer
    gly_bit_t push_data;
    logic push;
    logic fifo_ready;
    logic [LW-1:0] fifo_level;
    logic [LW-1:0] lvl_after;

    // detector outputs and scratch
    logic z0;
    logic z1;
    logic z2;
    logic efb;
    logic [22:0] tmp;
    logic [4:0] xidx;

    // number of ones in a syndrome-sized vector
    function automatic logic [3:0] gly_wt(input logic [10:0] v);
        logic [3:0] c;
        c = '0;
        for (int i = 0; i < 11; i++) begin
            c = c + 4'(v[i]);
        end
        return c;
    endfunction

    // threshold detectors on the current syndrome
    always_comb begin
        // a zero syndrome means nothing left to fix; skip needless passes
        z0 = (q.syn != '0) && (gly_wt(q.syn) <= GLY_WT_ALL);
        z1 = gly_wt(q.syn ^ GLY_SYN_A) <= GLY_WT_ONE;
        z2 = gly_wt(q.syn ^ GLY_SYN_B) <= GLY_WT_ONE;
    end

    // next state of encoder and decoder
    always_comb begin
        next_q = q;
        push = 1'b0;
        push_data = '0;
        tmp = '0;
        efb = 1'b0;
        xidx = '0;

        // ---- encoder ----
        // output slot frees when the link takes the bit
        if (q.ovalid && enc_out_ready) begin
            next_q.ovalid = 1'b0;
        end
        case (q.ephase)
            GLY_E_INFO: begin
                // info bits pass straight out and into the divider
                if (q.in_ready && enc_in_valid) begin
                    next_q.obit = '{last: 1'b0, data: enc_in_bit}; // see [R14]
                    next_q.ovalid = 1'b1;
                    efb = enc_in_bit ^ q.par[10];
                    next_q.par = {q.par[9:0], 1'b0} ^ (efb ? GLY_GEN_LOW : '0); // see [R12]
                    if (q.ecnt == 5'(GLY_K - 1)) begin
                        next_q.ecnt = '0;
                        next_q.ephase = GLY_E_PAR;
                    end else begin
                        next_q.ecnt = q.ecnt + 5'h1;
                    end
                end
            end
            GLY_E_PAR: begin
                // check bits follow, top stage first
                if (!q.ovalid) begin
                    next_q.obit = '{last: 1'b0, data: q.par[10]}; // see [R14]
                    next_q.ovalid = 1'b1;
                    next_q.par = {q.par[9:0], 1'b0};
                    if (q.ecnt == 5'(GLY_PAR - 1)) begin // see [R13]
                        next_q.ecnt = '0;
                        next_q.ephase = GLY_E_FILL;
                    end else begin
                        next_q.ecnt = q.ecnt + 5'h1;
                    end
                end
            end
            GLY_E_FILL: begin
                // fill bit keeps the block at exactly half rate
                if (!q.ovalid) begin
                    next_q.obit = '{last: 1'b1, data: GLY_FILL_VAL};
                    next_q.ovalid = 1'b1;
                    next_q.par = '0;
                    next_q.ephase = GLY_E_INFO;
                end
            end
            default: begin
                next_q.ephase = GLY_E_INFO;
            end
        endcase
        // at most one bit in flight, so the encoder runs at half rate
        next_q.in_ready = (next_q.ephase == GLY_E_INFO) && !next_q.ovalid;

        // ---- decoder ----
        case (q.phase)
            GLY_D_LOAD: begin
                if (q.rx_ready && rx_valid && fifo_ready) begin // see [R15]
                    if (q.cnt < 5'(GLY_N)) begin
                        // new bit enters, old corrected bit leaves the top
                        next_q.cw = {q.cw[21:0], rx_bit}; // see [R1]
                        next_q.syn = {q.syn[9:0], rx_bit}
                            ^ (q.syn[10] ? GLY_GEN_LOW : '0); // see [R1]
                        push = q.have_prev; // see [R11]
                        push_data = '{last: (q.cnt == 5'(GLY_N - 1)), data: q.cw[22]};
                        next_q.cnt = q.cnt + 5'h1;
                    end else begin
                        // fill position: taken off the wire, never looked at
                        next_q.cnt = '0; // see [R2]
                        next_q.steps = '0;
                        next_q.phase = GLY_D_TEST; // see [R3]
                    end
                end
            end
            GLY_D_TEST: begin
                // input and output are idle here; priority z0, z1, z2
                next_q.cnt = '0;
                if (z0) begin
                    next_q.xfix = 1'b0; // see [R4]
                    next_q.phase = GLY_D_CORR;
                end else if (z1) begin
                    // syndrome minus the extra error gives the low errors
                    next_q.syn = q.syn ^ GLY_SYN_A; // see [R6]
                    next_q.xcnt = GLY_PRE_A; // see [R6]
                    next_q.xfix = 1'b1;
                    next_q.phase = GLY_D_CORR;
                end else if (z2) begin
                    next_q.syn = q.syn ^ GLY_SYN_B; // see [R7]
                    next_q.xcnt = GLY_PRE_B; // see [R7]
                    next_q.xfix = 1'b1;
                    next_q.phase = GLY_D_CORR;
                end else begin
                    next_q.phase = GLY_D_SHIFT; // see [R8]
                end
            end
            GLY_D_CORR: begin
                // no feedback: syndrome bits are added into the codeword
                tmp = q.cw;
                tmp[10] = q.cw[10] ^ q.syn[10]; // see [R4]
                if (q.xfix) begin
                    xidx = GLY_EXTRA_BASE + 5'(q.xcnt);
                    tmp = tmp ^ (23'h1 << xidx); // see [R6] [R7]
                end
                next_q.xfix = 1'b0;
                next_q.cw = {tmp[21:0], tmp[22]};
                next_q.syn = {q.syn[9:0], 1'b0};
                if (q.cnt == 5'(GLY_PAR - 1)) begin // see [R4]
                    next_q.cnt = '0;
                    next_q.phase = GLY_D_ALIGN; // see [R5]
                end else begin
                    next_q.cnt = q.cnt + 5'h1;
                end
            end
            GLY_D_ALIGN: begin
                // correction off; rotate only the codeword back home
                next_q.cw = {q.cw[21:0], q.cw[22]}; // see [R5]
                if (q.cnt == 5'(GLY_ALIGN - 1)) begin
                    next_q.cnt = '0;
                    next_q.phase = GLY_D_SHIFT; // see [R5]
                end else begin
                    next_q.cnt = q.cnt + 5'h1;
                end
            end
            GLY_D_SHIFT: begin
                // one cyclic step of the word, syndrome follows with feedback;
                // register order is reversed, so this left move is the classic right shift
                next_q.cw = {q.cw[21:0], q.cw[22]}; // see [R9]
                next_q.syn = {q.syn[9:0], 1'b0}
                    ^ (q.syn[10] ? GLY_GEN_LOW : '0); // see [R9]
                if (q.steps == 6'(GLY_STEPS - 1)) begin
                    // two full turns: word is aligned and ready to leave
                    next_q.steps = '0;
                    next_q.syn = '0;
                    next_q.have_prev = 1'b1;
                    next_q.phase = GLY_D_LOAD; // see [R10]
                end else begin
                    next_q.steps = q.steps + 6'h1;
                    next_q.phase = GLY_D_TEST; // see [R9]
                end
            end
            default: begin
                next_q.phase = GLY_D_LOAD;
            end
        endcase

        // ready only if the buffer cannot overflow next cycle; a pop only helps
        lvl_after = fifo_level + LW'(push);
        next_q.rx_ready = (next_q.phase == GLY_D_LOAD)
            && (lvl_after < LW'(FIFO_DEPTH)); // see [R15]
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{phase: GLY_D_LOAD, cw: '0, syn: '0, cnt: '0, steps: '0,
                   xcnt: '0, xfix: 1'b0, have_prev: 1'b0, rx_ready: 1'b0,
                   ephase: GLY_E_INFO, ecnt: '0, par: '0, obit: '0,
                   ovalid: 1'b0, in_ready: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    // corrected bits wait here until the user side takes them
    gly_fifo #(
        .W($bits(gly_bit_t)),
        .DEPTH(FIFO_DEPTH),
        .LW(LW)
    ) u_out_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_data(push_data),
        .in_ready(fifo_ready),
        .out_valid(usr_valid),
        .out_data(usr_data),
        .out_ready(usr_ready),
        .level(fifo_level)
    );

    // all outputs straight from state flops
    assign enc_in_ready = q.in_ready;
    assign enc_out = q.obit;
    assign enc_out_valid = q.ovalid;
    assign rx_ready = q.rx_ready;

endmodule

`default_nettype wire

// ---- verif/gly_chk.sv ----
// port checker for the golay codec, bound onto every instance
`timescale 1ns/1ns
`default_nettype none
module gly_chk #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enc_in_bit,
    input wire logic enc_in_valid,
    input wire logic enc_in_ready,
    input wire gly_pkg::gly_bit_t enc_out,
    input wire logic enc_out_valid,
    input wire logic enc_out_ready,
    input wire logic rx_bit,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire gly_pkg::gly_bit_t usr_data,
    input wire logic usr_valid,
    input wire logic usr_ready
);
    import gly_pkg::*;
    // transfer counters; gap starts saturated so the first ready after reset passes
    typedef struct packed {
        logic [4:0] ecnt; // encoder bits taken in this block
        logic [4:0] rcnt; // receive bits taken in this block
        logic [4:0] ucnt; // user bits taken in this word
        logic [7:0] gap; // cycles since a fill bit was taken
    } gly_chk_t;
    gly_chk_t s;
    gly_chk_t next_s;
    wire logic e_go = enc_out_valid && enc_out_ready;
    wire logic r_go = rx_valid && rx_ready;
    wire logic u_go = usr_valid && usr_ready;
    wire logic r_fill = r_go && s.rcnt == 5'h17;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // next counter values
    always_comb begin
        next_s = s;
        if (e_go) next_s.ecnt = (s.ecnt == 5'h17) ? 5'h00 : s.ecnt + 5'h01;
        if (r_go) next_s.rcnt = (s.rcnt == 5'h17) ? 5'h00 : s.rcnt + 5'h01;
        if (u_go) next_s.ucnt = usr_data.last ? 5'h00 : s.ucnt + 5'h01;
        if (r_fill) begin
            next_s.gap = 8'h00;
        end else if (s.gap != 8'hFF) begin
            next_s.gap = s.gap + 8'h01;
        end
    end
    // counter registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) s <= {5'h00, 5'h00, 5'h00, 8'hFF};
        else s <= next_s;
    end
    enc_answer_a: assert property (enc_in_valid && enc_in_ready |=> enc_out_valid)
        else $error("encoder took a bit but showed no output");
    enc_pace_a: assert property (enc_in_valid && enc_in_ready |=> !enc_in_ready)
        else $error("encoder took two bits back to back");
    enc_hold_a: assert property (enc_out_valid && !enc_out_ready |=> enc_out_valid && $stable(enc_out))
        else $error("encoder output changed before it was taken");
    enc_frame_a: assert property (e_go |-> enc_out.last == (s.ecnt == 5'h17))
        else $error("encoder block end not on the 24th bit");
    fill_value_a: assert property (enc_out_valid && enc_out.last |-> enc_out.data == GLY_FILL_VAL)
        else $error("fill bit carries the wrong value");
    usr_hold_a: assert property (usr_valid && !usr_ready |=> usr_valid && $stable(usr_data))
        else $error("user output changed before it was taken");
    usr_frame_a: assert property (u_go && usr_data.last |-> s.ucnt == 5'h16)
        else $error("user word end not on the 23rd bit");
    load_stop_a: assert property (r_fill |=> (!rx_ready) [*8])
        else $error("decoder took input right after the fill bit");
    steps_min_a: assert property ($rose(rx_ready) |-> s.gap >= 8'h5C)
        else $error("decoder ready again before its shift steps");
    steps_max_a: assert property (r_fill |-> ##[92:1000] rx_ready)
        else $error("decoder never returned to loading");
endmodule
bind gly_codec gly_chk #(.FIFO_DEPTH(FIFO_DEPTH)) gly_chk_i (.clk(clk), .rst_n(rst_n),
    .enc_in_bit(enc_in_bit), .enc_in_valid(enc_in_valid), .enc_in_ready(enc_in_ready),
    .enc_out(enc_out), .enc_out_valid(enc_out_valid), .enc_out_ready(enc_out_ready),
    .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready), .usr_data(usr_data),
    .usr_valid(usr_valid), .usr_ready(usr_ready));
`default_nettype wire

// ---- verif/gly_link.sv ----
// receive-path model: carries encoder bits to the decoder, flipping masked ones
`timescale 1ns/1ns
`default_nettype none
module gly_link (
    input wire logic clk,
    input wire logic rst_n,
    input wire gly_pkg::gly_bit_t enc_out,
    input wire logic enc_out_valid,
    output logic enc_out_ready,
    output logic rx_bit,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [23:0] err, // bit 23 flips the first bit of a block
    input wire logic slow, // refuse every other cycle
    output logic [7:0] nblk // blocks handed to the decoder
);
    import gly_pkg::*;
    // one-bit holding slot, so the link never runs ahead of the decoder
    typedef struct packed {
        logic v; // slot full
        logic b; // bit held
        logic l; // held bit ends a block
        logic ph; // stall phase
        logic [4:0] idx; // bit position in block
        logic [7:0] nblk; // blocks delivered
    } gly_link_t;
    gly_link_t s;
    gly_link_t next_s;
    // take from the encoder, give to the decoder
    always_comb begin
        next_s = s;
        next_s.ph = !s.ph;
        if (enc_out_valid && enc_out_ready) begin
            next_s.v = 1'b1;
            next_s.b = enc_out.data ^ err[5'h17 - s.idx];
            next_s.l = enc_out.last;
            next_s.idx = enc_out.last ? 5'h00 : s.idx + 5'h01;
        end
        if (rx_valid && rx_ready) begin
            next_s.v = 1'b0;
            if (s.l) next_s.nblk = s.nblk + 8'h01;
        end
    end
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) s <= '0;
        else s <= next_s;
    end
    assign enc_out_ready = !s.v && !(slow && s.ph);
    assign rx_valid = s.v;
    // an empty slot shows the inverse so a stale bit is never mistaken for data
    assign rx_bit = s.v ? s.b : !s.b;
    assign nblk = s.nblk;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench: encoder looped through the link model into the decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import gly_pkg::*;
    typedef struct packed {
        logic [11:0] msg; // information bits, msb sent first
        logic [23:0] err; // link flips, fill at bit 0
    } gly_row_t;
    // every row holds three or fewer code-bit errors, so the word must come back intact
    gly_row_t rows [9] = '{{12'h000, 24'h000000}, {12'hFFF, 24'h000000},
        {12'hA5C, 24'h800000}, {12'h3C7, 24'h000002}, {12'h123, 24'h000001},
        {12'h5A5, 24'h810200}, {12'h9E1, 24'h000E00}, {12'h777, 24'h102003},
        {12'hBEE, 24'h060000}};
    logic clk, rst_n, ei_bit, ei_valid, usr_ready, slow;
    logic [23:0] err;
    wire logic ei_ready, eo_valid, eo_ready, rx_bit, rx_valid, rx_ready, usr_valid;
    wire logic [7:0] nblk;
    gly_bit_t eo, usr_data;
    int n_mismatch = 0;
    int n_tests = 0;
    int ecnt, ucnt;
    logic [23:0] ebuf, ubuf;
    logic [22:0] exp_q[$]; // words due at the user side
    logic [22:0] enc_q[$]; // words due on the link
    gly_codec gly_codec_i (.clk(clk), .rst_n(rst_n), .enc_in_bit(ei_bit),
        .enc_in_valid(ei_valid), .enc_in_ready(ei_ready), .enc_out(eo),
        .enc_out_valid(eo_valid), .enc_out_ready(eo_ready), .rx_bit(rx_bit),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .usr_data(usr_data),
        .usr_valid(usr_valid), .usr_ready(usr_ready));
    gly_link gly_link_i (.clk(clk), .rst_n(rst_n), .enc_out(eo), .enc_out_valid(eo_valid),
        .enc_out_ready(eo_ready), .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .err(err), .slow(slow), .nblk(nblk));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    // reference encoder: long division by x^11+x^10+x^6+x^5+x^4+x^2+1
    function automatic logic [22:0] enc(input logic [11:0] m);
        logic [10:0] r;
        r = 11'h000;
        for (int i = 11; i >= 0; i--) r = {r[9:0], 1'b0} ^ ((m[i] ^ r[10]) ? 11'h475 : 11'h000);
        return {m, r};
    endfunction
    // offer one word, then wait until its fill bit reached the decoder
    task automatic send(input gly_row_t w);
        int n;
        logic [7:0] b0;
        b0 = nblk;
        err <= w.err;
        enc_q.push_back(enc(w.msg));
        exp_q.push_back(enc(w.msg));
        for (int k = 11; k >= 0; k--) begin
            ei_bit <= w.msg[k];
            ei_valid <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ei_ready !== 1'b1 && n < 2000);
            // a hang is a failure, never a clean finish
            if (n >= 2000) begin
                n_mismatch++;
                give_verdict();
            end
        end
        ei_valid <= 1'b0;
        n = 0;
        while (nblk === b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // link and user monitors; bits arrive first-sent first
    always @(posedge clk) begin
        if (!rst_n) begin
            ecnt = 0;
            ucnt = 0;
        end
        if (eo_valid && eo_ready) begin
            ebuf = {ebuf[22:0], eo.data};
            ecnt++;
            if (eo.last) begin
                chk(ebuf, {enc_q.pop_front(), 1'b0});
                chk(24'(ecnt), 24'h18);
                ecnt = 0;
            end
        end
        if (usr_valid && usr_ready) begin
            ubuf = {ubuf[22:0], usr_data.data};
            ucnt++;
            if (usr_data.last) begin
                chk({1'b0, ubuf[22:0]}, {1'b0, exp_q.pop_front()});
                chk(24'(ucnt), 24'h17);
                ucnt = 0;
            end
        end
    end
    initial begin
        rst_n = 1'b0;
        ei_bit = 1'b0;
        ei_valid = 1'b0;
        usr_ready = 1'b1;
        slow = 1'b0;
        err = 24'h000000;
        repeat (6) @(posedge clk);
        chk({20'h0, ei_ready, rx_ready, eo_valid, usr_valid}, 24'h0);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (rows[i]) send(rows[i]);
        $display("test rows done");
        // user side stalls and the link dawdles: buffer fills and the decoder refuses
        usr_ready <= 1'b0;
        slow <= 1'b1;
        fork
            send(rows[5]);
            begin
                // decode of the previous word plus a corrected pass takes ~120 cycles
                repeat (300) @(posedge clk);
                chk({22'h0, usr_valid, rx_ready}, 24'h2);
                usr_ready <= 1'b1;
            end
        join
        slow <= 1'b0;
        $display("test stall done");
        // reset in mid-run drops everything held inside
        rst_n <= 1'b0;
        @(posedge clk);
        chk({20'h0, ei_ready, rx_ready, eo_valid, usr_valid}, 24'h0);
        exp_q.delete();
        enc_q.delete();
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({22'h0, ei_ready, rx_ready}, 24'h3);
        send(rows[7]);
        send(rows[2]);
        repeat (30) @(posedge clk);
        chk(24'(exp_q.size()), 24'h1);
        $display("test reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
